// file: common/drs_pkg.sv
// Constants and types shared by the run-command sequencer.
// Assumes a single 20 MHz control clock and settings held static by the owner.
package drs_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int MIN_PRESS_US = 1000;
   localparam int MIN_PRESS_CYCLES = (MIN_PRESS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TICK_MS = 100;
   localparam int TICK_CYCLES = (TICK_MS * 1000000) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int NUM_TERM = 8;
   localparam int FN_W = 6;
   localparam int FREQ_W = 16;
   localparam int TIME_W = 13;
   localparam int DWELL_W = 10;
   localparam int TICK_W = 21;
   localparam int QUAL_W = 16;

   // ---------------------------------------------------------------
   // Setting codes
   // ---------------------------------------------------------------
   localparam logic [2:0] SRC_FWD_REV_TERMINAL = 3'h1;
   localparam logic [FN_W-1:0] FN_RUN_PERMIT = 6'h0D;
   localparam logic [FN_W-1:0] FN_THREE_WIRE = 6'h0E;
   localparam logic PERMIT_UNGATED = 1'h0;
   localparam logic PERMIT_INPUT_GATED = 1'h1;
   localparam logic [1:0] LOSS_COAST = 2'h0;
   localparam logic [1:0] LOSS_QSTOP = 2'h1;
   localparam logic [1:0] LOSS_QSTOP_RESUME = 2'h2;

   // ---------------------------------------------------------------
   // Setting defaults (frequency in 0.01 Hz, time in 0.1 s)
   // ---------------------------------------------------------------
   localparam logic [TIME_W-1:0] QSTOP_TIME_DEF = 13'h0032;
   localparam logic [TIME_W-1:0] QSTOP_TIME_MAX = 13'h1770;
   localparam logic [FREQ_W-1:0] ACC_DWELL_FREQ_DEF = 16'h01F4;
   localparam logic [FREQ_W-1:0] DEC_DWELL_FREQ_DEF = 16'h01F4;
   localparam logic [DWELL_W-1:0] DWELL_TIME_DEF = 10'h000;
   localparam logic [DWELL_W-1:0] DWELL_TIME_MAX = 10'h258;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [FREQ_W-1:0] FREQ_RST = 16'h0000;
   localparam logic [TICK_W-1:0] TICK_RST = 21'h000000;
   localparam logic [DWELL_W-1:0] HOLD_RST = 10'h000;
   localparam logic [QUAL_W-1:0] QUAL_RST = 16'h0000;

   // Sequencer states, Gray along start -> run -> stop
   typedef enum logic [2:0] {
      ST_STOP = 3'h0,
      ST_ACCEL = 3'h1,
      ST_ACC_HOLD = 3'h3,
      ST_RUN = 3'h2,
      ST_DECEL = 3'h6,
      ST_DEC_HOLD = 3'h7,
      ST_QSTOP = 3'h5
   } drs_state_t;

endpackage : drs_pkg

// file: logic/drs_input_qual.sv
// Minimum-width qualifier for one pushbutton input.
// Assumes the input is already synchronous to clk.
module drs_input_qual #(
   parameter int MIN_CYCLES = drs_pkg::MIN_PRESS_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic rawIn,
   output logic qualOut
);

   logic [drs_pkg::QUAL_W-1:0] cnt_ff;
   logic lvl_ff;

   // Level follows input only after it stays different long enough
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= drs_pkg::QUAL_RST;
         lvl_ff <= 1'h0;
      end else if (rawIn == lvl_ff) begin
         cnt_ff <= drs_pkg::QUAL_RST;
      end else if (cnt_ff == drs_pkg::QUAL_W'(MIN_CYCLES - 1)) begin
         cnt_ff <= drs_pkg::QUAL_RST;
         lvl_ff <= rawIn;
      end else begin
         cnt_ff <= cnt_ff + 16'h0001;
      end
   end

   assign qualOut = lvl_ff;

endmodule : drs_input_qual

// file: logic/drs_run_sequencer.sv
// Run-command sequencer: three-wire latch, run-permit gating, dwell holds.
// Assumes settings are static while running and inputs are synchronous to clk.

// Function
// - Three-wire mode latches momentary forward/reverse presses
// - Forward and reverse together stop the motor
// - Run-permit function code alone does not gate
// - Gating select: 1 input-gated, 0 ungated
// - Coast action blocks output on permit loss
// - Quick stop; restart needs fresh run command
// - Quick stop; resume when permit returns running
// - Quick-stop time 0-600 s, default 5.0
// - Start ramps to acc dwell, holds, continues
// - Stop ramps to dec dwell, holds, stops
// - Zero hold time or frequency skips dwell
// - Acc dwell only on first run command
// - Dec dwell only after a stop command
// - External brake control disables both dwells
module drs_run_sequencer #(
   parameter int MIN_PRESS_CYCLES = drs_pkg::MIN_PRESS_CYCLES,
   parameter int TICK_CYCLES = drs_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] cmdSource,
   input wire logic fwdIn,
   input wire logic revIn,
   input wire logic [drs_pkg::NUM_TERM-1:0] termIn,
   input wire logic [drs_pkg::NUM_TERM*drs_pkg::FN_W-1:0] terminalFunctionAssign,
   input wire logic permitMode,
   input wire logic [1:0] lossAction,
   input wire logic [drs_pkg::TIME_W-1:0] qStopTime,
   input wire logic [drs_pkg::FREQ_W-1:0] setFreq,
   input wire logic [drs_pkg::FREQ_W-1:0] maxFreq,
   input wire logic [drs_pkg::TIME_W-1:0] accTime,
   input wire logic [drs_pkg::TIME_W-1:0] decTime,
   input wire logic [drs_pkg::FREQ_W-1:0] accDwellFreq,
   input wire logic [drs_pkg::DWELL_W-1:0] accDwellTime,
   input wire logic [drs_pkg::FREQ_W-1:0] decDwellFreq,
   input wire logic [drs_pkg::DWELL_W-1:0] decDwellTime,
   input wire logic brakeCtrlActive,
   output logic [drs_pkg::FREQ_W-1:0] freqOut,
   output logic reverseDir,
   output logic outputEnable,
   output logic dwellActive,
   output logic quickStopActive,
   output logic latchedRun
);

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   function automatic logic termAssigned(input logic [47:0] fn, input logic [5:0] code);
      logic hit;
      hit = 1'h0;
      for (int i = 0; i < drs_pkg::NUM_TERM; i++) begin
         if (fn[i*drs_pkg::FN_W +: drs_pkg::FN_W] == code) hit = 1'h1;
      end
      return hit;
   endfunction : termAssigned

   function automatic logic termLevel(input logic [47:0] fn, input logic [7:0] lv,
                                      input logic [5:0] code);
      logic hit;
      hit = 1'h0;
      for (int i = 0; i < drs_pkg::NUM_TERM; i++) begin
         if (fn[i*drs_pkg::FN_W +: drs_pkg::FN_W] == code && lv[i]) hit = 1'h1;
      end
      return hit;
   endfunction : termLevel

   // Frequency change per 0.1 s tick: span over time, at least one count
   function automatic logic [15:0] rampStep(input logic [15:0] span, input logic [12:0] t);
      logic [15:0] q;
      q = (t == 13'h0000) ? span : span / {3'h0, t};
      if (q == 16'h0000) q = 16'h0001;
      return q;
   endfunction : rampStep

   function automatic logic [15:0] rampTo(input logic [15:0] cur, input logic [15:0] tgt,
                                          input logic [15:0] step);
      logic [16:0] sum;
      logic [15:0] diff;
      sum = {1'h0, cur} + {1'h0, step};
      diff = cur - tgt;
      if (cur < tgt) return (sum >= {1'h0, tgt}) ? tgt : sum[15:0];
      return (diff <= step) ? tgt : cur - step;
   endfunction : rampTo

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   drs_pkg::drs_state_t state_ff, nxt_state;
   logic [drs_pkg::FREQ_W-1:0] freq_ff, nxt_freq;
   logic [drs_pkg::DWELL_W-1:0] holdCnt_ff, nxt_holdCnt;
   logic [drs_pkg::TICK_W-1:0] tickCnt_ff;
   logic dir_ff, nxt_dir, decPend_ff, nxt_decPend, outEn_ff;
   logic runFwd_ff, runRev_ff, qLock_ff;
   logic tick, fwdQ, revQ, threeWireEn, stopLvl, gateActive, permitOk;
   logic cmdFwd, cmdRev, runReq, startOk, stopReq, permitLost;
   logic accDwellEn, decDwellEn, stopPend;
   logic [drs_pkg::FREQ_W-1:0] accStep, decStep, qStep, rampNext;

   // ---------------------------------------------------------------
   // Tick divider and input qualifiers
   // ---------------------------------------------------------------
   assign tick = (tickCnt_ff == drs_pkg::TICK_W'(TICK_CYCLES - 1));

   // 0.1 s enable pulse
   always_ff @(posedge clk or posedge rst) begin
      if (rst) tickCnt_ff <= drs_pkg::TICK_RST;
      else tickCnt_ff <= tick ? drs_pkg::TICK_RST : tickCnt_ff + 21'h000001;
   end

   drs_input_qual #(.MIN_CYCLES(MIN_PRESS_CYCLES)) fwdQual (
      .clk(clk), .rst(rst), .rawIn(fwdIn), .qualOut(fwdQ));
   drs_input_qual #(.MIN_CYCLES(MIN_PRESS_CYCLES)) revQual (
      .clk(clk), .rst(rst), .rawIn(revIn), .qualOut(revQ));

   // ---------------------------------------------------------------
   // Command decode and permit gating
   // ---------------------------------------------------------------
   assign threeWireEn = (cmdSource == drs_pkg::SRC_FWD_REV_TERMINAL) &&
                        termAssigned(terminalFunctionAssign, drs_pkg::FN_THREE_WIRE);
   assign stopLvl = termLevel(terminalFunctionAssign, termIn, drs_pkg::FN_THREE_WIRE);
   assign gateActive = (permitMode == drs_pkg::PERMIT_INPUT_GATED) &&
                       termAssigned(terminalFunctionAssign, drs_pkg::FN_RUN_PERMIT);
   assign permitOk = !gateActive ||
                     termLevel(terminalFunctionAssign, termIn, drs_pkg::FN_RUN_PERMIT);
   assign permitLost = !permitOk;
   assign cmdFwd = threeWireEn ? runFwd_ff : fwdIn;
   assign cmdRev = threeWireEn ? runRev_ff : revIn;
   assign runReq = cmdFwd ^ cmdRev;
   assign startOk = runReq && permitOk && !qLock_ff;
   assign stopReq = !runReq || (cmdRev != dir_ff);

   // Three-wire latch of momentary presses
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         runFwd_ff <= 1'h0;
         runRev_ff <= 1'h0;
      end else if (!threeWireEn || !stopLvl) begin
         runFwd_ff <= 1'h0;
         runRev_ff <= 1'h0;
      end else if (fwdQ && revQ) begin
         runFwd_ff <= 1'h0;
         runRev_ff <= 1'h0;
      end else if (fwdQ) begin
         runFwd_ff <= 1'h1;
         runRev_ff <= 1'h0;
      end else if (revQ) begin
         runFwd_ff <= 1'h0;
         runRev_ff <= 1'h1;
      end
   end

   // Quick-stop lockout until the run command drops; loss wins over clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) qLock_ff <= 1'h0;
      else if (permitLost && lossAction == drs_pkg::LOSS_QSTOP && runReq) qLock_ff <= 1'h1;
      else if (!runReq) qLock_ff <= 1'h0;
   end

   // ---------------------------------------------------------------
   // Dwell and ramp terms
   // ---------------------------------------------------------------
   assign accDwellEn = accDwellTime != 10'h000 && accDwellFreq != 16'h0000 &&
                       !brakeCtrlActive;
   assign decDwellEn = decDwellTime != 10'h000 && decDwellFreq != 16'h0000 &&
                       !brakeCtrlActive;
   assign stopPend = decDwellEn && freq_ff > decDwellFreq;
   assign accStep = rampStep(maxFreq, accTime);
   assign decStep = rampStep(maxFreq, decTime);
   assign qStep = rampStep(maxFreq, qStopTime);
   assign rampNext = rampTo(freq_ff, setFreq, (freq_ff < setFreq) ? accStep : decStep);

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   // Next state, frequency, hold count and direction
   always_comb begin
      nxt_state = state_ff;
      nxt_freq = freq_ff;
      nxt_holdCnt = holdCnt_ff;
      nxt_dir = dir_ff;
      nxt_decPend = decPend_ff;
      if (permitLost && lossAction == drs_pkg::LOSS_COAST) begin
         nxt_state = drs_pkg::ST_STOP;
         nxt_freq = drs_pkg::FREQ_RST;
      end else if (permitLost && state_ff != drs_pkg::ST_STOP &&
                   state_ff != drs_pkg::ST_QSTOP) begin
         nxt_state = drs_pkg::ST_QSTOP;
      end else begin
         unique case (state_ff)
            drs_pkg::ST_STOP: begin
               nxt_freq = drs_pkg::FREQ_RST;
               nxt_decPend = 1'h0;
               if (startOk) begin
                  nxt_dir = cmdRev;
                  nxt_state = accDwellEn ? drs_pkg::ST_ACCEL : drs_pkg::ST_RUN;
               end
            end
            drs_pkg::ST_ACCEL: begin
               if (stopReq) begin
                  nxt_state = drs_pkg::ST_DECEL;
                  nxt_decPend = stopPend;
               end else if (tick && rampNext >= accDwellFreq) begin
                  nxt_freq = accDwellFreq;
                  nxt_holdCnt = accDwellTime;
                  nxt_state = drs_pkg::ST_ACC_HOLD;
               end else if (tick) begin
                  nxt_freq = rampNext;
                  if (rampNext == setFreq) nxt_state = drs_pkg::ST_RUN;
               end
            end
            drs_pkg::ST_ACC_HOLD: begin
               if (stopReq) begin
                  nxt_state = drs_pkg::ST_DECEL;
                  nxt_decPend = stopPend;
               end else if (tick) begin
                  nxt_holdCnt = holdCnt_ff - 10'h001;
                  if (holdCnt_ff <= 10'h001) nxt_state = drs_pkg::ST_RUN;
               end
            end
            drs_pkg::ST_RUN: begin
               if (stopReq) begin
                  nxt_state = drs_pkg::ST_DECEL;
                  nxt_decPend = stopPend;
               end else if (tick) begin
                  nxt_freq = rampNext;
               end
            end
            drs_pkg::ST_DECEL: begin
               if (startOk && cmdRev == dir_ff) begin
                  nxt_state = drs_pkg::ST_RUN;
               end else if (tick) begin
                  nxt_freq = rampTo(freq_ff, drs_pkg::FREQ_RST, decStep);
                  if (decPend_ff && decDwellEn && nxt_freq <= decDwellFreq) begin
                     nxt_freq = decDwellFreq;
                     nxt_holdCnt = decDwellTime;
                     nxt_decPend = 1'h0;
                     nxt_state = drs_pkg::ST_DEC_HOLD;
                  end else if (nxt_freq == drs_pkg::FREQ_RST) begin
                     nxt_state = drs_pkg::ST_STOP;
                  end
               end
            end
            drs_pkg::ST_DEC_HOLD: begin
               if (startOk && cmdRev == dir_ff) begin
                  nxt_state = drs_pkg::ST_RUN;
               end else if (tick) begin
                  nxt_holdCnt = holdCnt_ff - 10'h001;
                  if (holdCnt_ff <= 10'h001) nxt_state = drs_pkg::ST_DECEL;
               end
            end
            drs_pkg::ST_QSTOP: begin
               if (permitOk && lossAction == drs_pkg::LOSS_QSTOP_RESUME && runReq &&
                   cmdRev == dir_ff) begin
                  nxt_state = drs_pkg::ST_RUN;
               end else if (tick) begin
                  nxt_freq = rampTo(freq_ff, drs_pkg::FREQ_RST, qStep);
                  if (nxt_freq == drs_pkg::FREQ_RST) nxt_state = drs_pkg::ST_STOP;
               end
            end
            default: begin
               nxt_state = drs_pkg::ST_STOP;
               nxt_freq = drs_pkg::FREQ_RST;
            end
         endcase
      end
   end

   // Sequencer registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= drs_pkg::ST_STOP;
         freq_ff <= drs_pkg::FREQ_RST;
         holdCnt_ff <= drs_pkg::HOLD_RST;
         dir_ff <= 1'h0;
         decPend_ff <= 1'h0;
         outEn_ff <= 1'h0;
      end else begin
         state_ff <= nxt_state;
         freq_ff <= nxt_freq;
         holdCnt_ff <= nxt_holdCnt;
         dir_ff <= nxt_dir;
         decPend_ff <= nxt_decPend;
         outEn_ff <= (nxt_state != drs_pkg::ST_STOP);
      end
   end

   // Outputs
   assign freqOut = freq_ff;
   assign reverseDir = dir_ff;
   assign outputEnable = outEn_ff;
   assign dwellActive = (state_ff == drs_pkg::ST_ACC_HOLD) || (state_ff == drs_pkg::ST_DEC_HOLD);
   assign quickStopActive = (state_ff == drs_pkg::ST_QSTOP);
   assign latchedRun = runFwd_ff | runRev_ff;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   both_dirs_stop_a: assert property (@(posedge clk) disable iff (rst)
      (cmdFwd && cmdRev && state_ff == drs_pkg::ST_STOP) |=> !outEn_ff)
      else $error("both directions did not stop");
   latch_keep_a: assert property (@(posedge clk) disable iff (rst)
      (threeWireEn && stopLvl && fwdQ && !revQ) |=> runFwd_ff && !runRev_ff)
      else $error("forward press not latched");
   latch_clear_a: assert property (@(posedge clk) disable iff (rst)
      (threeWireEn && !stopLvl) |=> !runFwd_ff && !runRev_ff)
      else $error("stop terminal did not clear latch");
   ungated_permit_a: assert property (@(posedge clk) disable iff (rst)
      (permitMode == drs_pkg::PERMIT_UNGATED) |-> permitOk)
      else $error("ungated mode still gates");
   coast_block_a: assert property (@(posedge clk) disable iff (rst)
      (permitLost && lossAction == drs_pkg::LOSS_COAST) |=> !outputEnable && freqOut == 16'h0000)
      else $error("coast did not block output");
   qstop_enter_a: assert property (@(posedge clk) disable iff (rst)
      (permitLost && lossAction != drs_pkg::LOSS_COAST && state_ff == drs_pkg::ST_RUN)
      |=> state_ff == drs_pkg::ST_QSTOP)
      else $error("quick stop not entered");
   qstop_lock_a: assert property (@(posedge clk) disable iff (rst)
      (qLock_ff && state_ff == drs_pkg::ST_STOP) |=> state_ff == drs_pkg::ST_STOP)
      else $error("restart without fresh command");
   qstop_resume_a: assert property (@(posedge clk) disable iff (rst)
      (state_ff == drs_pkg::ST_QSTOP && permitOk && runReq && cmdRev == dir_ff &&
       lossAction == drs_pkg::LOSS_QSTOP_RESUME) |=> state_ff == drs_pkg::ST_RUN)
      else $error("quick stop did not resume");
   acc_hold_freq_a: assert property (@(posedge clk) disable iff (rst)
      (state_ff != drs_pkg::ST_ACC_HOLD ##1 state_ff == drs_pkg::ST_ACC_HOLD)
      |-> freq_ff == $past(accDwellFreq) && $past(accDwellEn))
      else $error("acc hold at wrong frequency or disabled");
   no_acc_resume_a: assert property (@(posedge clk) disable iff (rst)
      (state_ff == drs_pkg::ST_DECEL || state_ff == drs_pkg::ST_QSTOP)
      |=> state_ff != drs_pkg::ST_ACC_HOLD && state_ff != drs_pkg::ST_ACCEL)
      else $error("acc dwell during resume");
   dec_hold_stop_a: assert property (@(posedge clk) disable iff (rst)
      state_ff == drs_pkg::ST_RUN |=> state_ff != drs_pkg::ST_DEC_HOLD)
      else $error("dec dwell without stop");
   brake_no_dwell_a: assert property (@(posedge clk) disable iff (rst)
      (brakeCtrlActive && state_ff != drs_pkg::ST_DEC_HOLD) |=> state_ff != drs_pkg::ST_DEC_HOLD)
      else $error("dwell with brake control");

endmodule : drs_run_sequencer

// file: bench/drs_button_model.sv
// Pushbutton and switch model driving the forward and reverse run inputs.
// Assumes a free-running clk; lines change 5 ns after a rising edge.
module drs_button_model (
   input wire logic clk,
   output logic fwdOut,
   output logic revOut
);
   timeunit 1ns;
   timeprecision 1ns;

   // Released buttons read low through a pull-down
   initial begin
      fwdOut = 1'b0;
      revOut = 1'b0;
   end

   // Momentary press held for n cycles, then released
   task automatic press(input logic f, input logic r, input int n);
      @(posedge clk) #5;
      fwdOut = f;
      revOut = r;
      repeat (n) @(posedge clk);
      #5;
      fwdOut = 1'b0;
      revOut = 1'b0;
   endtask : press

   // Maintained switch levels
   task automatic level(input logic f, input logic r);
      @(posedge clk) #5;
      fwdOut = f;
      revOut = r;
   endtask : level
endmodule : drs_button_model

// file: bench/drs_run_sequencer_tb_top.sv
// Self-checking bench for the run-command sequencer.
// Assumes short press and tick counts; expected values come from integer models.
module drs_run_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int MINP = 4;
   localparam int TICK = 8;
   logic clk, rst, permitMode, brakeCtrlActive, reverseDir, outputEnable;
   logic dwellActive, quickStopActive, latchedRun, fwdIn, revIn, sawDwell;
   logic [2:0] cmdSource;
   logic [1:0] lossAction;
   logic [7:0] termIn;
   logic [47:0] terminalFunctionAssign;
   logic [12:0] qStopTime, accTime, decTime;
   logic [9:0] accDwellTime, decDwellTime;
   logic [15:0] setFreq, maxFreq, accDwellFreq, decDwellFreq, freqOut, runFreq;
   int fails, comparisons, seed, n, t;

   drs_button_model i_btn (.clk(clk), .fwdOut(fwdIn), .revOut(revIn));
   drs_run_sequencer #(.MIN_PRESS_CYCLES(MINP), .TICK_CYCLES(TICK)) i_dut (
      .clk(clk), .rst(rst), .cmdSource(cmdSource), .fwdIn(fwdIn), .revIn(revIn),
      .termIn(termIn), .terminalFunctionAssign(terminalFunctionAssign),
      .permitMode(permitMode), .lossAction(lossAction), .qStopTime(qStopTime),
      .setFreq(setFreq), .maxFreq(maxFreq), .accTime(accTime), .decTime(decTime),
      .accDwellFreq(accDwellFreq), .accDwellTime(accDwellTime),
      .decDwellFreq(decDwellFreq), .decDwellTime(decDwellTime),
      .brakeCtrlActive(brakeCtrlActive), .freqOut(freqOut), .reverseDir(reverseDir),
      .outputEnable(outputEnable), .dwellActive(dwellActive),
      .quickStopActive(quickStopActive), .latchedRun(latchedRun));

   // Clock and dwell monitor
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) if (dwellActive === 1'b1) sawDwell = 1'b1;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #5;
   endtask : tick
   task automatic chkFreq(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: freqOut %h, expected %h", $time, got, exp);
      end
   endtask : chkFreq
   task automatic chkFlag(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s is %b", $time, what, got);
      end
   endtask : chkFlag
   task automatic waitFreq(input logic [15:0] f, input int lim);
      for (n = 0; n < lim && freqOut !== f; n++) tick(1);
      chkFreq(freqOut, f);
   endtask : waitFreq
   task automatic waitDwell(input int lim);
      for (n = 0; n < lim && dwellActive !== 1'b1; n++) tick(1);
      chkFlag(dwellActive, 1'b1, "dwellActive");
   endtask : waitDwell
   task automatic results;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results

   // Watchdog
   initial begin
      #(50 * 20000);
      fails++;
      results();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      seed = 32'hFA59;
      runFreq = 16'h0BB8 + 16'($random(seed) & 32'h3FF);
      rst = 1'b1; sawDwell = 1'b0; cmdSource = 3'h1; termIn = 8'h03;
      terminalFunctionAssign = 48'h00000000034E; // Term0 three-wire, term1 permit
      permitMode = 1'b0; lossAction = 2'h0; qStopTime = drs_pkg::QSTOP_TIME_DEF;
      setFreq = runFreq; maxFreq = 16'h1770; accTime = 13'h000A; decTime = 13'h000A;
      accDwellFreq = drs_pkg::ACC_DWELL_FREQ_DEF; decDwellFreq = drs_pkg::DEC_DWELL_FREQ_DEF;
      accDwellTime = 10'h000; decDwellTime = 10'h000; brakeCtrlActive = 1'b0;
      tick(2);
      rst = 1'b0;
      // Three-wire latch, short pulse refused
      i_btn.press(1'b1, 1'b0, MINP + 2);
      chkFlag(latchedRun, 1'b1, "latchedRun");
      waitFreq(runFreq, 200);
      i_btn.press(1'b0, 1'b1, MINP - 2);
      tick(10);
      chkFlag(reverseDir, 1'b0, "reverseDir");
      termIn = 8'h02;
      tick(2);
      chkFlag(latchedRun, 1'b0, "latchedRun");
      waitFreq(16'h0000, 300);
      tick(2);
      chkFlag(outputEnable, 1'b0, "outputEnable");
      chkFlag(sawDwell, 1'b0, "sawDwell");
      $display("test latch done");
      // Level mode, both directions, ungated then gated permit with coast
      terminalFunctionAssign = 48'h000000000340;
      termIn = 8'h00;
      i_btn.level(1'b1, 1'b1);
      tick(20);
      chkFlag(outputEnable, 1'b0, "outputEnable");
      i_btn.level(1'b0, 1'b1);
      waitFreq(runFreq, 200);
      chkFlag(reverseDir, 1'b1, "reverseDir");
      i_btn.level(1'b1, 1'b0);
      waitFreq(16'h0000, 200);
      waitFreq(runFreq, 200);
      chkFlag(reverseDir, 1'b0, "reverseDir");
      termIn = 8'h02;
      permitMode = 1'b1;
      tick(2);
      termIn = 8'h00;
      tick(1);
      chkFlag(outputEnable, 1'b0, "outputEnable");
      chkFreq(freqOut, 16'h0000);
      $display("test gating done");
      // Quick stop without and with resume
      lossAction = 2'h1;
      termIn = 8'h02;
      i_btn.level(1'b0, 1'b0);
      tick(2);
      i_btn.level(1'b1, 1'b0);
      waitFreq(runFreq, 200);
      termIn = 8'h00;
      tick(1);
      chkFlag(quickStopActive, 1'b1, "quickStopActive");
      t = (int'(runFreq) + 119) / 120;
      waitFreq(16'h0000, 400);
      chkFlag(n >= (t - 1) * TICK && n <= (t + 1) * TICK, 1'b1, "ramp span");
      termIn = 8'h02;
      tick(30);
      chkFlag(outputEnable, 1'b0, "outputEnable");
      i_btn.level(1'b0, 1'b0);
      tick(2);
      i_btn.level(1'b1, 1'b0);
      waitFreq(runFreq, 200);
      lossAction = 2'h2;
      termIn = 8'h00;
      tick(24);
      termIn = 8'h02;
      waitFreq(runFreq, 200);
      chkFlag(quickStopActive, 1'b0, "quickStopActive");
      $display("test quick stop done");
      // Dwell holds
      i_btn.level(1'b0, 1'b0);
      waitFreq(16'h0000, 300);
      tick(3);
      accDwellTime = 10'h002; decDwellTime = 10'h002; decTime = 13'h0064;
      i_btn.level(1'b1, 1'b0);
      waitDwell(100);
      chkFreq(freqOut, drs_pkg::ACC_DWELL_FREQ_DEF);
      waitFreq(runFreq, 300);
      sawDwell = 1'b0;
      setFreq = 16'h00C8;
      waitFreq(16'h00C8, 900);
      chkFlag(sawDwell, 1'b0, "sawDwell");
      setFreq = 16'h07D0;
      waitFreq(16'h07D0, 100);
      i_btn.level(1'b0, 1'b0);
      waitDwell(400);
      chkFreq(freqOut, drs_pkg::DEC_DWELL_FREQ_DEF);
      tick(30);
      sawDwell = 1'b0;
      i_btn.level(1'b1, 1'b0);
      waitFreq(16'h07D0, 300);
      chkFlag(sawDwell, 1'b0, "sawDwell");
      i_btn.level(1'b0, 1'b0);
      waitFreq(16'h0000, 1000);
      decTime = 13'h000A; brakeCtrlActive = 1'b1;
      tick(3);
      sawDwell = 1'b0;
      i_btn.level(1'b1, 1'b0);
      waitFreq(16'h07D0, 300);
      i_btn.level(1'b0, 1'b0);
      waitFreq(16'h0000, 300);
      chkFlag(sawDwell, 1'b0, "sawDwell");
      $display("test dwell done");
      results();
   end
endmodule : drs_run_sequencer_tb_top
